// ==== design/vsd_top.sv ====
// Bus slave decode, reset defaults, channel scan store and fault lamp.
// Operation
// R1 - Respond only to modifiers 2D and 29.
// R2 - Claim 256-byte block, act on two bytes.
// R3 - High and low switches form base digits.
// R4 - Factory switch positions decode to B200.
// R5 - Host places no other slave in block.
// R6 - Reset selects standard 22 ms slot speed.
// R7 - Reset makes 60 Hz rejection active.
// R8 - Reset enables every channel for scanning.
// R9 - Reset zeroes data; fresh after 35 slots.
// R10 - Reset selects 5 V range per channel.
// R11 - Reset clears all filter constants.
// R12 - Reset disables all channel alarms.
// R13 - Reset sets fail high on open sensor.
// R14 - Fault lamp on during reset or fault.
// R15 - Lamp held half second after reset.
// R16 - Scan channels, store latest result each.
// R17 - Readable alarm flag for limit violation.
// R18 - Hold defaults while bus reset asserted.
//
// Design decisions made here: the address-and-strobe port and the register offsets.
`timescale 1ns/1ns
module vsd_top #(
    parameter int SLOT_CYC = vsd_pkg::VSD_SLOT_CYC,
    parameter int LAMP_CYC = vsd_pkg::VSD_LAMP_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic bus_sysreset_n,
    input wire logic [15:0] bus_addr,
    input wire logic [5:0] bus_am,
    input wire logic bus_strobe,
    input wire logic [3:0] base_addr_high_switch,
    input wire logic [3:0] base_addr_low_switch,
    input wire logic [15:0] conv_result,
    input wire logic conv_open,
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    output logic bus_select,
    output logic bus_select_stat,
    output logic [2:0] scan_chan,
    output logic fast_mode,
    output logic reject_50hz,
    output logic fault_lamp,
    output logic alarm_flag,
    output logic irq
);
    import vsd_pkg::*;

    logic [1:0] sysrst_sync_q;
    logic [3:0] sw_hi_a_q, sw_hi_b_q, sw_lo_a_q, sw_lo_b_q;
    logic [15:0] addr_a_q, addr_b_q;
    logic [5:0] am_a_q, am_b_q;
    logic strb_a_q, strb_b_q;
    logic [15:0] conv_a_q, conv_b_q;
    logic open_a_q, open_b_q;
    vsd_state_type state_q;
    logic [31:0] lamp_cnt_q, slot_cnt_q;
    logic [5:0] slots_q;
    logic [7:0] ctrl_q, chen_q, alen_q;
    logic [2:0] sel_q;
    logic [2:0] status_q, mask_q;
    logic [15:0] data_q [VSD_CHANNELS];
    logic [15:0] lim_q [VSD_CHANNELS];
    logic [1:0] range_q [VSD_CHANNELS];
    logic [7:0] filt_q [VSD_CHANNELS];
    logic failhi_q [VSD_CHANNELS];
    logic [7:0] viol_q;
    logic defaults_load, slot_tick, soft_rst, hit, hit_d, hit_q;
    logic [2:0] st_set;

    // Two-flop synchronisers on the bus, switch and converter inputs; only the second stage is read.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sysrst_sync_q <= 2'h0;
            sw_hi_a_q <= 4'h0;
            sw_hi_b_q <= 4'h0;
            sw_lo_a_q <= 4'h0;
            sw_lo_b_q <= 4'h0;
            addr_a_q <= 16'h0000;
            addr_b_q <= 16'h0000;
            am_a_q <= 6'h00;
            am_b_q <= 6'h00;
            strb_a_q <= 1'b0;
            strb_b_q <= 1'b0;
            conv_a_q <= 16'h0000;
            conv_b_q <= 16'h0000;
            open_a_q <= 1'b0;
            open_b_q <= 1'b0;
        end else begin
            sysrst_sync_q <= {sysrst_sync_q[0], bus_sysreset_n};
            sw_hi_a_q <= base_addr_high_switch;
            sw_hi_b_q <= sw_hi_a_q;
            sw_lo_a_q <= base_addr_low_switch;
            sw_lo_b_q <= sw_lo_a_q;
            addr_a_q <= bus_addr;
            addr_b_q <= addr_a_q;
            am_a_q <= bus_am;
            am_b_q <= am_a_q;
            strb_a_q <= bus_strobe;
            strb_b_q <= strb_a_q;
            conv_a_q <= conv_result;
            conv_b_q <= conv_a_q;
            open_a_q <= conv_open;
            open_b_q <= open_a_q;
        end
    end

    // Decode: modifier match and the two switch digits against the top byte.
    // The whole block is claimed so no stray slave can alias into it.
    always_comb begin
        hit = strb_b_q && (am_b_q == VSD_AM_SUPER || am_b_q == VSD_AM_USER); // R1
        hit = hit && (addr_b_q[15:8] == {sw_hi_b_q, sw_lo_b_q}); // R2 R3 R5
        hit_d = hit && (addr_b_q[7:1] == 7'h00); // R2
    end

    // Bus select outputs registered so they come straight from flops.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bus_select <= 1'b0;
            bus_select_stat <= 1'b0;
            hit_q <= 1'b0;
        end else begin
            bus_select <= hit;
            bus_select_stat <= hit_d && (addr_b_q[7:0] == VSD_OFS_STAT);
            hit_q <= hit_d;
        end
    end

    // Decode checks: a select needs a legal modifier and the switch digits.
    a_am_filter: assert property (@(posedge clk) disable iff (!rst_n) // R1
        bus_select |-> $past(am_b_q == VSD_AM_SUPER || am_b_q == VSD_AM_USER))
        else $error("select with wrong modifier");
    a_block_claim: assert property (@(posedge clk) disable iff (!rst_n) // R2
        bus_select |-> $past(addr_b_q[15:8] == {sw_hi_b_q, sw_lo_b_q}))
        else $error("select outside block");
    a_two_bytes: assert property (@(posedge clk) disable iff (!rst_n) // R2
        hit_q |-> $past(addr_b_q[7:1]) == 7'h00)
        else $error("active byte beyond two");
    a_stat_byte: assert property (@(posedge clk) disable iff (!rst_n) // R2
        bus_select_stat |-> bus_select)
        else $error("status byte without block select");
    a_switch_digits: assert property (@(posedge clk) disable iff (!rst_n) // R3
        $past(hit) |-> bus_select)
        else $error("switch decode missed");
    a_base_factory: assert property (@(posedge clk) disable iff (!rst_n) // R4
        (sw_hi_b_q == VSD_SW_HIGH_DEF && sw_lo_b_q == VSD_SW_LOW_DEF && strb_b_q
         && am_b_q == VSD_AM_SUPER && addr_b_q == 16'hB200) |=> bus_select)
        else $error("B200 not decoded");

    // Reset sequence: hold while bus reset or soft reset, then time the lamp.
    assign soft_rst = reg_wr && reg_addr == VSD_REG_CTRL && reg_wdata[VSD_CT_SOFTRST];
    assign defaults_load = (state_q != VSD_RUN);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= VSD_RESET;
            lamp_cnt_q <= 32'h0;
        end else if (!sysrst_sync_q[1] || soft_rst) begin
            state_q <= VSD_RESET; // R18
            lamp_cnt_q <= 32'h0;
        end else begin
            unique case (state_q)
                VSD_RESET: state_q <= VSD_HOLD;
                VSD_HOLD: begin
                    lamp_cnt_q <= lamp_cnt_q + 32'h1;
                    if (lamp_cnt_q >= 32'(LAMP_CYC - 1)) state_q <= VSD_RUN; // R15
                end
                VSD_RUN: state_q <= VSD_RUN;
            endcase
        end
    end

    // Sequence checks: a bus reset or a soft reset restarts the lamp timing.
    a_lamp_hold: assert property (@(posedge clk) disable iff (!rst_n) // R18
        !sysrst_sync_q[1] |=> state_q == VSD_RESET ##1 fault_lamp)
        else $error("bus reset not held");
    a_soft_restart: assert property (@(posedge clk) disable iff (!rst_n) // R15
        soft_rst |=> state_q == VSD_RESET)
        else $error("soft reset did not restart");

    // Fault lamp: reset in progress or a fault flagged by software.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) fault_lamp <= 1'b1;
        else fault_lamp <= defaults_load || ctrl_q[VSD_CT_FAULT]; // R14 R15
    end

    // Lamp checks: lit through the whole reset, dark once running without a fault.
    a_lamp_reset: assert property (@(posedge clk) disable iff (!rst_n) // R14
        defaults_load |=> fault_lamp)
        else $error("lamp off during reset");
    a_lamp_release: assert property (@(posedge clk) disable iff (!rst_n) // R15
        state_q == VSD_RUN && !ctrl_q[VSD_CT_FAULT] |=> !fault_lamp)
        else $error("lamp stuck after reset");

    // Board configuration registers with their reset defaults.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= VSD_CTRL_RST;
            chen_q <= VSD_CHEN_RST;
            alen_q <= VSD_ALEN_RST;
            sel_q <= 3'h0;
        end else if (defaults_load) begin
            ctrl_q <= VSD_CTRL_RST; // R6 R7
            chen_q <= VSD_CHEN_RST; // R8
            alen_q <= VSD_ALEN_RST; // R12
        end else if (reg_wr) begin
            if (reg_addr == VSD_REG_CTRL) ctrl_q <= {reg_wdata[7:3], 1'b0, reg_wdata[1:0]};
            if (reg_addr == VSD_REG_CHEN) chen_q <= reg_wdata[7:0];
            if (reg_addr == VSD_REG_ALEN) alen_q <= reg_wdata[7:0];
            if (reg_addr == VSD_REG_SEL) sel_q <= reg_wdata[2:0];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fast_mode <= 1'b0;
            reject_50hz <= 1'b0;
        end else begin
            fast_mode <= ctrl_q[VSD_CT_FAST];
            reject_50hz <= ctrl_q[VSD_CT_REJ50];
        end
    end

    // Board register defaults, one cycle after a load; the mode pins follow a cycle later.
    a_speed_default: assert property (@(posedge clk) disable iff (!rst_n) // R6
        defaults_load |=> !ctrl_q[VSD_CT_FAST] && !ctrl_q[VSD_CT_REJ50])
        else $error("speed or rejection default");
    a_rej_default: assert property (@(posedge clk) disable iff (!rst_n) // R7
        defaults_load |=> ##1 !reject_50hz)
        else $error("60 Hz not default");
    a_chen_default: assert property (@(posedge clk) disable iff (!rst_n) // R8
        defaults_load |=> chen_q == VSD_CHEN_RST && alen_q == VSD_ALEN_RST)
        else $error("channel enable defaults");
    a_alarm_default: assert property (@(posedge clk) disable iff (!rst_n) // R12
        defaults_load |=> alen_q == VSD_ALEN_RST)
        else $error("alarms not disabled");

    // Slot timer: one enable pulse per channel slot, stepping through all channels; the store skips disabled ones.
    assign slot_tick = !defaults_load && slot_cnt_q >= 32'(SLOT_CYC - 1);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            slot_cnt_q <= 32'h0;
            scan_chan <= 3'h0;
            slots_q <= 6'h0;
        end else if (defaults_load) begin
            slot_cnt_q <= 32'h0;
            scan_chan <= 3'h0;
            slots_q <= 6'h0;
        end else if (slot_tick) begin
            slot_cnt_q <= 32'h0;
            scan_chan <= scan_chan + 3'h1; // R16
            if (slots_q < 6'(VSD_FRESH_SLOTS)) slots_q <= slots_q + 6'h1; // R9
        end else begin
            slot_cnt_q <= slot_cnt_q + 32'h1;
        end
    end

    // Scan check: every slot pulse moves on to the next channel.
    a_slot_step: assert property (@(posedge clk) disable iff (!rst_n) // R16
        slot_tick |=> scan_chan == $past(scan_chan) + 3'h1)
        else $error("scan channel did not step");

    // Per-channel store, configuration and limit check.
    generate
        for (genvar c = 0; c < VSD_CHANNELS; c++) begin : g_chan
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    data_q[c] <= 16'h0000;
                    range_q[c] <= VSD_RANGE_5V;
                    filt_q[c] <= VSD_FILT_RST;
                    failhi_q[c] <= VSD_FAIL_HIGH;
                    lim_q[c] <= 16'h0000;
                end else if (defaults_load) begin
                    data_q[c] <= 16'h0000; // R9
                    range_q[c] <= VSD_RANGE_5V; // R10
                    filt_q[c] <= VSD_FILT_RST; // R11
                    failhi_q[c] <= VSD_FAIL_HIGH; // R13
                end else begin
                    if (slot_tick && scan_chan == 3'(c) && chen_q[c])
                        data_q[c] <= (open_b_q && failhi_q[c]) ? VSD_FULL_SCALE : conv_b_q; // R16
                    if (reg_wr && reg_addr == VSD_REG_CFG && sel_q == 3'(c)) begin
                        range_q[c] <= reg_wdata[1:0];
                        failhi_q[c] <= reg_wdata[2];
                        filt_q[c] <= reg_wdata[15:8];
                    end
                    if (reg_wr && reg_addr == VSD_REG_DATA && sel_q == 3'(c))
                        lim_q[c] <= reg_wdata;
                end
            end
            assign viol_q[c] = alen_q[c] && (data_q[c] > lim_q[c]);
        end
    endgenerate

    // Channel checks on sample channels, one cycle after a load or a slot.
    a_data_zero: assert property (@(posedge clk) disable iff (!rst_n) // R9
        defaults_load |=> data_q[0] == 16'h0000 && slots_q == 6'h0)
        else $error("data not cleared");
    a_cfg_default: assert property (@(posedge clk) disable iff (!rst_n) // R10
        defaults_load |=> range_q[7] == VSD_RANGE_5V && filt_q[7] == VSD_FILT_RST
        && failhi_q[7])
        else $error("channel config defaults");
    a_filt_default: assert property (@(posedge clk) disable iff (!rst_n) // R11
        defaults_load |=> filt_q[0] == VSD_FILT_RST)
        else $error("filter not cleared");
    a_fail_high: assert property (@(posedge clk) disable iff (!rst_n) // R13
        defaults_load |=> failhi_q[4] && range_q[4] == VSD_RANGE_5V)
        else $error("open sensor not failing high");
    a_store_slot: assert property (@(posedge clk) disable iff (!rst_n) // R16
        slot_tick && scan_chan == 3'h2 && chen_q[2] && !open_b_q
        |=> data_q[2] == $past(conv_b_q))
        else $error("scan result not stored");

    // Alarm flag visible to the host without touching sensor data.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) alarm_flag <= 1'b0;
        else alarm_flag <= |viol_q; // R17
    end

    // Alarm check: any enabled violation shows on the flag a cycle later.
    a_alarm_flag: assert property (@(posedge clk) disable iff (!rst_n) // R17
        (|viol_q) |=> alarm_flag)
        else $error("alarm flag missed");

    // Sticky status: set wins over a write-one clear.
    assign st_set = {slots_q == 6'(VSD_FRESH_SLOTS - 1) && slot_tick, |viol_q, hit_q};
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            status_q <= 3'h0;
            mask_q <= 3'h0;
        end else begin
            if (reg_wr && reg_addr == VSD_REG_STATUS)
                status_q <= (status_q & ~reg_wdata[2:0]) | st_set;
            else
                status_q <= status_q | st_set;
            if (reg_wr && reg_addr == VSD_REG_MASK) mask_q <= reg_wdata[2:0];
        end
    end

    // Fresh check: the last of the settling slots sets the ready bit, even under a clear.
    a_fresh_status: assert property (@(posedge clk) disable iff (!rst_n) // R9
        slot_tick && slots_q == 6'(VSD_FRESH_SLOTS - 1) |=> status_q[VSD_ST_READY])
        else $error("fresh status missed");

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) irq <= 1'b0;
        else irq <= |(status_q & mask_q);
    end

    // Interrupt check: an unmasked status bit raises the line a cycle later.
    a_irq_level: assert property (@(posedge clk) disable iff (!rst_n)
        (|(status_q & mask_q)) |=> irq)
        else $error("interrupt not raised");

    // Read port: data one cycle after the strobe, zero otherwise.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) reg_rdata <= 16'h0000;
        else if (reg_rd) begin
            unique case (reg_addr)
                VSD_REG_STATUS: reg_rdata <= {13'h0, status_q};
                VSD_REG_MASK: reg_rdata <= {13'h0, mask_q};
                VSD_REG_CTRL: reg_rdata <= {8'h00, ctrl_q};
                VSD_REG_CHEN: reg_rdata <= {8'h00, chen_q};
                VSD_REG_ALEN: reg_rdata <= {8'h00, alen_q};
                VSD_REG_SEL: reg_rdata <= {13'h0, sel_q};
                VSD_REG_DATA: reg_rdata <= data_q[sel_q];
                VSD_REG_CFG: reg_rdata <= {filt_q[sel_q], 5'h00, failhi_q[sel_q], range_q[sel_q]};
                default: reg_rdata <= 16'h0000;
            endcase
        end else reg_rdata <= 16'h0000;
    end

    // Read data stand for one cycle only, so a stale word never lingers on the port.
    a_rd_zero: assert property (@(posedge clk) disable iff (!rst_n)
        !$past(reg_rd) |-> reg_rdata == 16'h0000)
        else $error("read data outside read cycle");
endmodule : vsd_top

// ==== design/vsd_pkg.sv ====
// Package of constants and types for the bus slave decode and reset default block.
package vsd_pkg;
    // Address modifier codes accepted for short space cycles.
    localparam logic [5:0] VSD_AM_SUPER = 6'h2D;
    localparam logic [5:0] VSD_AM_USER = 6'h29;
    // Factory switch positions give a base of B200.
    localparam logic [3:0] VSD_SW_HIGH_DEF = 4'hB;
    localparam logic [3:0] VSD_SW_LOW_DEF = 4'h2;
    // Byte locations inside the claimed block that carry behaviour.
    localparam logic [7:0] VSD_OFS_DATA = 8'h00;
    localparam logic [7:0] VSD_OFS_STAT = 8'h01;
    // Register offsets on the local register port.
    localparam logic [3:0] VSD_REG_STATUS = 4'h0;
    localparam logic [3:0] VSD_REG_MASK = 4'h1;
    localparam logic [3:0] VSD_REG_CTRL = 4'h2;
    localparam logic [3:0] VSD_REG_CHEN = 4'h3;
    localparam logic [3:0] VSD_REG_ALEN = 4'h4;
    localparam logic [3:0] VSD_REG_SEL = 4'h5;
    localparam logic [3:0] VSD_REG_DATA = 4'h6;
    localparam logic [3:0] VSD_REG_CFG = 4'h7;
    // Status bit positions.
    localparam int VSD_ST_CYCLE = 0;
    localparam int VSD_ST_ALARM = 1;
    localparam int VSD_ST_READY = 2;
    // Control bit positions.
    localparam int VSD_CT_FAST = 0;
    localparam int VSD_CT_REJ50 = 1;
    localparam int VSD_CT_SOFTRST = 2;
    localparam int VSD_CT_FAULT = 3;
    // Reset defaults.
    localparam logic [7:0] VSD_CTRL_RST = 8'h00;
    localparam logic [7:0] VSD_CHEN_RST = 8'hFF;
    localparam logic [7:0] VSD_ALEN_RST = 8'h00;
    localparam logic [1:0] VSD_RANGE_5V = 2'h0;
    localparam logic [7:0] VSD_FILT_RST = 8'h00;
    localparam logic VSD_FAIL_HIGH = 1'b1;
    localparam logic [15:0] VSD_FULL_SCALE = 16'h7FFF;
    localparam int VSD_CHANNELS = 8;
    localparam int VSD_FRESH_SLOTS = 35;
    // Timing: clock, slot time, fault lamp time.
    localparam int VSD_CLK_MHZ = 100;
    localparam int VSD_SLOT_MS = 22;
    localparam int VSD_LAMP_MS = 500;
    localparam int VSD_SLOT_CYC = VSD_SLOT_MS * 1000 * VSD_CLK_MHZ;
    localparam int VSD_LAMP_CYC = VSD_LAMP_MS * 1000 * VSD_CLK_MHZ;
    typedef enum logic [1:0] {VSD_RESET, VSD_HOLD, VSD_RUN} vsd_state_type;
endpackage : vsd_pkg

// ==== sim/vsd_host_model.sv ====
// Bus master model that drives the short space cycle pins and the system reset pin.
`timescale 1ns/1ns
module vsd_host_model (
    input wire logic clk,
    output logic [15:0] bus_addr,
    output logic [5:0] bus_am,
    output logic bus_strobe,
    output logic bus_sysreset_n
);
    // Idle bus: no strobe, and the address lines show a pattern rather than a stale value.
    initial begin
        bus_addr = 16'h5A5A;
        bus_am = 6'h3F;
        bus_strobe = 1'b0;
        bus_sysreset_n = 1'b1;
    end

    // Only addresses of this one slave are put inside its block, so no other slave answers there.
    task automatic start_cycle(input logic [15:0] addr, input logic [5:0] am);
        @(posedge clk);
        bus_addr <= addr;
        bus_am <= am;
        bus_strobe <= 1'b1;
    endtask : start_cycle

    // Release inverts the lines, since a released bus does not keep its last value.
    task automatic end_cycle();
        @(posedge clk);
        bus_strobe <= 1'b0;
        bus_addr <= ~bus_addr;
        bus_am <= ~bus_am;
    endtask : end_cycle

    // A stretched system reset is held low for the given number of cycles.
    task automatic sys_reset(input int cycles);
        @(posedge clk);
        bus_sysreset_n <= 1'b0;
        repeat (cycles) @(posedge clk);
        bus_sysreset_n <= 1'b1;
    endtask : sys_reset
endmodule : vsd_host_model

// ==== sim/tb_vme_slave_decode_reset_defaults.sv ====
// Self-checking testbench for the bus slave decode and reset default block.
`timescale 1ns/1ns
module tb_vme_slave_decode_reset_defaults;
    import vsd_pkg::*;
    localparam int SLOT = 20;
    localparam int LAMP = 50;
    logic clk, rst_n, bus_sysreset_n, bus_strobe, conv_open, reg_wr, reg_rd;
    logic [15:0] bus_addr, conv_result, reg_wdata, reg_rdata, v;
    logic [5:0] bus_am;
    logic [3:0] sw_hi, sw_lo, reg_addr;
    logic bus_select, bus_select_stat, fast_mode, reject_50hz, fault_lamp, alarm_flag, irq;
    logic [2:0] scan_chan;
    int num_errors = 0;
    int checked = 0;
    int cycles = 0;
    int n;
    logic [15:0] dec_a [6] = '{16'hB200, 16'hB201, 16'hB2FF, 16'hB300, 16'hB201, 16'hA200};
    logic [5:0] dec_m [6] = '{6'h2D, 6'h29, 6'h2D, 6'h2D, 6'h39, 6'h29};
    logic [1:0] dec_e [6] = '{2'b10, 2'b11, 2'b10, 2'b00, 2'b00, 2'b00};

    vsd_top #(.SLOT_CYC(SLOT), .LAMP_CYC(LAMP)) u_dut (.clk(clk), .rst_n(rst_n),
        .bus_sysreset_n(bus_sysreset_n), .bus_addr(bus_addr), .bus_am(bus_am),
        .bus_strobe(bus_strobe), .base_addr_high_switch(sw_hi), .base_addr_low_switch(sw_lo),
        .conv_result(conv_result), .conv_open(conv_open), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .bus_select(bus_select), .bus_select_stat(bus_select_stat), .scan_chan(scan_chan),
        .fast_mode(fast_mode), .reject_50hz(reject_50hz), .fault_lamp(fault_lamp),
        .alarm_flag(alarm_flag), .irq(irq));
    vsd_host_model u_host (.clk(clk), .bus_addr(bus_addr), .bus_am(bus_am),
        .bus_strobe(bus_strobe), .bus_sysreset_n(bus_sysreset_n));

    // Clock of 10 ns period.
    always #5 clk = ~clk;

    // Cycle ceiling well above the fewer than two thousand cycles the tests need.
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors++;
            $display("[FAIL] %0t timeout", $time);
            close_out();
        end
    end

    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : close_out

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr

    // Read data stand only in the cycle after the strobe, so they are taken there.
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd

    task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp, input string what);
        rd(a, v);
        chk(v, exp, what);
    endtask : rd_chk

    // Counts cycles until the fault lamp goes dark, bounded.
    task automatic wait_lamp(output int cnt);
        cnt = 0;
        while (fault_lamp !== 1'b0 && cnt < 300) begin
            @(posedge clk);
            #1 cnt++;
        end
    endtask : wait_lamp

    // Main sequence: defaults, scan, alarm, decode, control, resets.
    initial begin
        clk = 0; rst_n = 0; reg_addr = '0; reg_wdata = '0; reg_wr = 0; reg_rd = 0;
        sw_hi = VSD_SW_HIGH_DEF; sw_lo = VSD_SW_LOW_DEF; conv_result = 16'h1234; conv_open = 0;
        @(posedge clk);
        #1 chk(fault_lamp, 1'b1, "lamp in reset");
        @(posedge clk);
        rst_n <= 1'b1;
        rd_chk(VSD_REG_CTRL, VSD_CTRL_RST, "ctrl default");
        rd_chk(VSD_REG_CHEN, 16'h00FF, "chen default");
        rd_chk(VSD_REG_ALEN, 16'h0000, "alen default");
        for (int c = 0; c < 8; c++) begin
            wr(VSD_REG_SEL, 16'(c));
            rd_chk(VSD_REG_CFG, 16'h0004, "cfg default");
            rd_chk(VSD_REG_DATA, 16'h0000, "data zero");
        end
        wait_lamp(n);
        chk(16'(n < 300), 16'h1, "lamp falls");
        rd(VSD_REG_STATUS, v);
        chk(v[VSD_ST_READY], 1'b0, "not fresh yet");
        $display("Test defaults done");
        repeat (10 * SLOT) @(posedge clk);
        wr(VSD_REG_SEL, 16'h0003);
        rd_chk(VSD_REG_DATA, 16'h1234, "stored data");
        n = scan_chan;
        repeat (SLOT) @(posedge clk);
        #1 chk(scan_chan, 3'(n + 1), "scan steps");
        conv_open <= 1'b1;
        repeat (10 * SLOT) @(posedge clk);
        wr(VSD_REG_SEL, 16'h0005);
        rd_chk(VSD_REG_DATA, VSD_FULL_SCALE, "open fails high");
        conv_open <= 1'b0;
        repeat (25 * SLOT) @(posedge clk);
        rd(VSD_REG_STATUS, v);
        chk(v[VSD_ST_READY], 1'b1, "fresh after slots");
        $display("Test scan done");
        wr(VSD_REG_SEL, 16'h0000);
        wr(VSD_REG_DATA, 16'h0100);
        wr(VSD_REG_ALEN, 16'h0001);
        repeat (10 * SLOT) @(posedge clk);
        #1 chk(alarm_flag, 1'b1, "alarm flag");
        chk(irq, 1'b0, "irq masked");
        wr(VSD_REG_MASK, 16'h0002);
        repeat (2) @(posedge clk);
        #1 chk(irq, 1'b1, "irq raised");
        wr(VSD_REG_DATA, 16'hFFFF);
        repeat (10 * SLOT) @(posedge clk);
        wr(VSD_REG_STATUS, 16'h0002);
        repeat (2) @(posedge clk);
        #1 chk({alarm_flag, irq}, 2'b00, "alarm cleared");
        rd_chk(4'hF, 16'h0000, "unmapped reads zero");
        $display("Test alarm done");
        for (int i = 0; i < 7; i++) begin
            if (i == 6) begin
                sw_hi <= 4'h3;
                sw_lo <= 4'h7;
            end
            u_host.start_cycle(i == 6 ? 16'h3701 : dec_a[i], i == 6 ? 6'h2D : dec_m[i]);
            repeat (5) @(posedge clk);
            #1 chk({bus_select, bus_select_stat}, i == 6 ? 2'b11 : dec_e[i], "decode");
            u_host.end_cycle();
            repeat (5) @(posedge clk);
        end
        rd(VSD_REG_STATUS, v);
        chk(v[VSD_ST_CYCLE], 1'b1, "bus hit status");
        $display("Test decode done");
        wr(VSD_REG_CTRL, 16'h0003);
        repeat (2) @(posedge clk);
        #1 chk({fast_mode, reject_50hz}, 2'b11, "modes set");
        wr(VSD_REG_CTRL, 16'h000B);
        repeat (3) @(posedge clk);
        #1 chk(fault_lamp, 1'b1, "fault lights lamp");
        wr(VSD_REG_CFG, 16'h5A01);
        rd_chk(VSD_REG_CFG, 16'h5A01, "cfg written");
        wr(VSD_REG_CTRL, 16'h0004);
        repeat (3) @(posedge clk);
        #1 chk(fault_lamp, 1'b1, "soft reset lamp");
        wait_lamp(n);
        chk(16'(n >= LAMP - 8 && n <= LAMP + 6), 16'h1, "soft lamp time");
        chk({fast_mode, reject_50hz}, 2'b00, "soft defaults");
        rd_chk(VSD_REG_ALEN, 16'h0000, "soft alen");
        rd_chk(VSD_REG_CFG, 16'h0004, "soft cfg default");
        $display("Test soft reset done");
        wr(VSD_REG_CHEN, 16'h000F);
        u_host.sys_reset(100);
        #1 chk(fault_lamp, 1'b1, "lamp held in bus reset");
        rd_chk(VSD_REG_CHEN, 16'h00FF, "chen after bus reset");
        wait_lamp(n);
        chk(16'(n >= LAMP - 6 && n <= LAMP + 8), 16'h1, "hard lamp time");
        $display("Test bus reset done");
        close_out();
    end
endmodule : tb_vme_slave_decode_reset_defaults
